// File: rtl/sbi_pkg.sv
// Shared constants for the pipelined system bus master and slave ends.
package sbi_pkg;

  // Bus widths.
  localparam int ADDR_W = 32; // System address width.
  localparam int DATA_W = 32; // Read and write data width.

  // Transfer type codes.
  localparam logic [1:0] TRANS_IDLE = 2'h0; // No transfer wanted.
  localparam logic [1:0] TRANS_BUSY = 2'h1; // Master pauses inside a burst.
  localparam logic [1:0] TRANS_NONSEQ = 2'h2; // First or single transfer.
  localparam logic [1:0] TRANS_SEQ = 2'h3; // Following beat of a burst.
  localparam int TRANS_ACTIVE_BIT = 1; // High for NONSEQ and SEQ.

  // Transfer size codes, byte up to 1024 bits.
  localparam logic [2:0] SIZE_BYTE = 3'h0; // 8 bits.
  localparam logic [2:0] SIZE_HALF = 3'h1; // 16 bits.
  localparam logic [2:0] SIZE_WORD = 3'h2; // 32 bits.
  localparam logic [2:0] SIZE_1024 = 3'h7; // Widest code, 1024 bits.

  // Burst codes.
  localparam logic [2:0] BURST_SINGLE = 3'h0; // Single transfer.
  localparam logic [2:0] BURST_INCR = 3'h1; // Incrementing, open length.
  localparam logic [2:0] BURST_WRAP4 = 3'h2; // Four beats, wrapping.
  localparam logic [2:0] BURST_INCR4 = 3'h3; // Four beats, incrementing.
  localparam logic [2:0] BURST_WRAP8 = 3'h4; // Eight beats, wrapping.
  localparam logic [2:0] BURST_INCR8 = 3'h5; // Eight beats, incrementing.
  localparam logic [2:0] BURST_WRAP16 = 3'h6; // Sixteen beats, wrapping.
  localparam logic [2:0] BURST_INCR16 = 3'h7; // Sixteen beats, incrementing.

  // Protection field bit positions.
  localparam int PROT_DATA_BIT = 0; // High for data, low for opcode fetch.
  localparam int PROT_PRIV_BIT = 1; // High for privileged access.
  localparam int PROT_BUF_BIT = 2; // High when bufferable.
  localparam int PROT_CACHE_BIT = 3; // High when cacheable.

  // Response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0; // Transfer fine.
  localparam logic [1:0] RESP_ERROR = 2'h1; // Transfer failed.
  localparam logic [1:0] RESP_RETRY = 2'h2; // Master should try again.
  localparam logic [1:0] RESP_SPLIT = 2'h3; // Transfer split off.

  // Slave memory and decode.
  localparam int MEM_WORDS = 16; // Words held by the slave.
  localparam int IDX_W = 4; // Word index width.
  localparam int IDX_LSB = 2; // Lowest address bit of the word index.
  localparam int LANE_W = 2; // Byte lane address bits.
  localparam logic [31:0] SLAVE_BASE = 32'h0000_0000; // Slave base address.
  localparam logic [31:0] SLAVE_MASK = 32'hffff_ffc0; // Bits compared by decode.
  localparam logic [1:0] WAIT_STATES = 2'h1; // Extra cycles per good transfer.
  localparam logic [3:0] LANE_ALL = 4'hf; // All four byte lanes.
  localparam logic [3:0] LANE_HALF = 4'h3; // Low halfword lanes.
  localparam logic [3:0] LANE_BYTE = 4'h1; // Lowest byte lane.

endpackage : sbi_pkg

// File: rtl/sbi_if.sv
// Bus wiring between one master end and one slave end, with the address decoder.
`timescale 1ns/10ps
interface sbi_if;

  logic [31:0] haddr; // Address from master.
  logic [1:0] htrans; // Transfer type from master.
  logic hwrite; // High for write.
  logic [2:0] hsize; // Transfer size.
  logic [2:0] hburst; // Burst type.
  logic [3:0] hprot; // Protection field.
  logic [31:0] hwdata; // Write data bus.
  logic hsel; // Slave select from decoder.
  logic [31:0] hrdata; // Read data bus.
  logic hready_out; // Ready driven by the slave.
  logic hready; // Ready as seen on the bus.
  logic [1:0] hresp; // Slave response.

  // The decoder is a pure combinational compare of the address.
  assign hsel = ((haddr & sbi_pkg::SLAVE_MASK) == sbi_pkg::SLAVE_BASE);

  // With a single slave the bus ready is that slave's ready.
  assign hready = hready_out;

  modport master (
    output haddr,
    output htrans,
    output hwrite,
    output hsize,
    output hburst,
    output hprot,
    output hwdata,
    input hrdata,
    input hready,
    input hresp
  );

  modport slave (
    input haddr,
    input htrans,
    input hwrite,
    input hsize,
    input hburst,
    input hprot,
    input hwdata,
    input hsel,
    input hready,
    output hrdata,
    output hready_out,
    output hresp
  );

endinterface : sbi_if

// File: rtl/sbi_master.sv
// Master end: turns single user commands into address and data phases on the bus.
`timescale 1ns/10ps
module sbi_master (
  input wire logic clk, // Bus clock, rising edge only.
  input wire logic rst_n, // Active low reset.
  sbi_if.master bus, // Bus side.
  input wire logic cmd_valid, // User offers a command.
  input wire logic cmd_write, // High for write.
  input wire logic [31:0] cmd_addr, // Target address.
  input wire logic [2:0] cmd_size, // Transfer size code.
  input wire logic [3:0] cmd_prot, // Protection bits.
  input wire logic [31:0] cmd_wdata, // Write data.
  output logic cmd_ready, // Master idle and able to take a command.
  output logic rsp_valid, // One-cycle pulse when a transfer ends.
  output logic [31:0] rsp_data, // Read data of the ended transfer.
  output logic [1:0] rsp_code // Response of the ended transfer.
);

  typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA} sbi_mstate_e;

  sbi_mstate_e st, next_st; // Phase of the current transfer.
  logic [31:0] haddr, next_haddr; // Registered address.
  logic [1:0] htrans, next_htrans; // Registered transfer type.
  logic hwrite, next_hwrite; // Registered direction.
  logic [2:0] hsize, next_hsize; // Registered size.
  logic [3:0] hprot, next_hprot; // Registered protection.
  logic [31:0] wbuf, next_wbuf; // Write data held until the data phase.
  logic [31:0] hwdata, next_hwdata; // Registered write data.
  logic next_cmd_ready; // Next idle flag.
  logic next_rsp_valid; // Next end pulse.
  logic [31:0] next_rsp_data; // Next captured read data.
  logic [1:0] next_rsp_code; // Next captured response.

  // All bus outputs but hburst, which is tied to single, come straight from flops launched on the rising edge.
  assign bus.haddr = haddr;
  assign bus.htrans = htrans;
  assign bus.hwrite = hwrite;
  assign bus.hsize = hsize;
  assign bus.hburst = sbi_pkg::BURST_SINGLE;
  assign bus.hprot = hprot;
  assign bus.hwdata = hwdata;

  // Next-state logic; the address phase ends, and the data phase ends, on ready high.
  always_comb begin
    next_st = st;
    next_haddr = haddr;
    next_htrans = htrans;
    next_hwrite = hwrite;
    next_hsize = hsize;
    next_hprot = hprot;
    next_wbuf = wbuf;
    next_hwdata = hwdata;
    next_cmd_ready = cmd_ready;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_rsp_code = rsp_code;
    case (st)
      M_IDLE: begin
        // A command is taken only while idle, so transfers never overlap.
        if (cmd_valid && cmd_ready) begin
          next_haddr = cmd_addr;
          next_htrans = sbi_pkg::TRANS_NONSEQ;
          next_hwrite = cmd_write;
          next_hsize = cmd_size;
          next_hprot = cmd_prot;
          next_wbuf = cmd_wdata;
          next_cmd_ready = 1'b0;
          next_st = M_ADDR;
        end
      end
      M_ADDR: begin
        // Address taken; write data follows one phase behind on its own bus.
        if (bus.hready) begin
          next_htrans = sbi_pkg::TRANS_IDLE;
          next_hwdata = wbuf;
          next_st = M_DATA;
        end
      end
      M_DATA: begin
        // Low ready stretches the data phase; the first cycle of a two-cycle
        // response is simply waited out.
        if (bus.hready) begin
          next_rsp_valid = 1'b1;
          next_rsp_data = bus.hrdata;
          next_rsp_code = bus.hresp;
          next_cmd_ready = 1'b1;
          next_st = M_IDLE;
        end
      end
      default: begin
        next_st = M_IDLE;
        next_cmd_ready = 1'b1;
      end
    endcase
  end

  // Registers only; reset is the sole active-low signal.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= M_IDLE;
      haddr <= 32'h0000_0000;
      htrans <= sbi_pkg::TRANS_IDLE;
      hwrite <= 1'b0;
      hsize <= sbi_pkg::SIZE_WORD;
      hprot <= 4'h0;
      wbuf <= 32'h0000_0000;
      hwdata <= 32'h0000_0000;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= 32'h0000_0000;
      rsp_code <= sbi_pkg::RESP_OKAY;
    end else begin
      st <= next_st;
      haddr <= next_haddr;
      htrans <= next_htrans;
      hwrite <= next_hwrite;
      hsize <= next_hsize;
      hprot <= next_hprot;
      wbuf <= next_wbuf;
      hwdata <= next_hwdata;
      cmd_ready <= next_cmd_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      rsp_code <= next_rsp_code;
    end
  end

endmodule : sbi_master

// File: rtl/sbi_slave.sv
// Slave end: a small word memory behind the bus, with wait states and error answers.
//
// Summary of operation
// - All bus signals timed on clock rising edge.
// - Reset active low; no other signal is.
// - Master drives a 32-bit address.
// - Two-bit type: nonseq, seq, idle, busy.
// - Direction high writes, low reads.
// - Three-bit size: byte, halfword, word.
// - Size codes reach up to 1024 bits.
// - Three-bit burst field, 4/8/16, incr/wrap.
// - Protection marks fetch/data and privileged/user.
// - MMU masters add cacheable and bufferable.
// - Write data on its own bus.
// - Selected slave returns read data.
// - Data buses at least 32 bits.
// - Each slave select decoded combinationally from address.
// - Slave raises ready when transfer completes.
// - Slave holds ready low to stretch transfers.
// - Slave has ready as input and output.
// - Two-bit response: okay, error, retry, split.
// - Arbitration lines are point-to-point, suffixed per master.
`timescale 1ns/10ps
module sbi_slave (
  input wire logic clk, // Bus clock, rising edge only.
  input wire logic rst_n, // Active low reset.
  sbi_if.slave bus, // Bus side.
  output logic wr_strobe, // One-cycle pulse when a write lands.
  output logic [3:0] wr_index, // Word index of the landed write.
  output logic [31:0] wr_word, // Word content after the write.
  output logic [31:0] xfer_count // Transfers accepted since reset.
);

  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_ERR} sbi_sstate_e;

  localparam int ONE_W = 32; // Width of the transfer counter.

  sbi_sstate_e st, next_st; // Data-phase state.
  logic [1:0] wait_cnt, next_wait_cnt; // Wait states still to insert.
  logic hready_out, next_hready_out; // Own ready output.
  logic [1:0] hresp, next_hresp; // Own response output.
  logic [31:0] hrdata, next_hrdata; // Own read data output.
  logic pend, next_pend; // A good transfer is in its data phase.
  logic pend_write, next_pend_write; // Direction of that transfer.
  logic [3:0] pend_idx, next_pend_idx; // Word index of that transfer.
  logic [3:0] pend_lanes, next_pend_lanes; // Byte lanes of that transfer.
  logic [31:0] mem [sbi_pkg::MEM_WORDS]; // Storage words.
  logic [31:0] next_mem [sbi_pkg::MEM_WORDS]; // Next storage words.
  logic next_wr_strobe; // Next write pulse.
  logic [3:0] next_wr_index; // Next write index.
  logic [31:0] next_wr_word; // Next written word.
  logic [31:0] next_xfer_count; // Next transfer count.

  // Combinational helpers from the address and data phases.
  logic accept; // Address phase of an active transfer aimed here.
  logic size_ok; // Size fits the 32-bit data path.
  logic [3:0] a_idx; // Word index from the address.
  logic [3:0] a_lanes; // Byte lanes from size and low address bits.
  logic completing; // The pending data phase ends this cycle.
  logic [31:0] merged; // Pending word with write data merged in.

  // Drive the bus from flops only.
  assign bus.hrdata = hrdata;
  assign bus.hready_out = hready_out;
  assign bus.hresp = hresp;

  // Lane selection: the low address bits pick which bytes a narrow write touches.
  function automatic logic [3:0] sbi_lanes(input logic [2:0] size, input logic [1:0] lo);
    logic [3:0] l;
    l = sbi_pkg::LANE_ALL;
    case (size)
      sbi_pkg::SIZE_BYTE: l = sbi_pkg::LANE_BYTE << lo;
      sbi_pkg::SIZE_HALF: l = sbi_pkg::LANE_HALF << {lo[1], 1'b0};
      default: l = sbi_pkg::LANE_ALL;
    endcase
    return l;
  endfunction : sbi_lanes

  // Address phase decode. A transfer counts only when this slave is selected,
  // the bus is ready and the type is nonsequential or sequential; idle and busy
  // get a plain zero-wait okay and touch nothing.
  always_comb begin
    accept = bus.hsel && bus.hready && bus.htrans[sbi_pkg::TRANS_ACTIVE_BIT];
    size_ok = (bus.hsize <= sbi_pkg::SIZE_WORD);
    a_idx = bus.haddr[sbi_pkg::IDX_LSB +: sbi_pkg::IDX_W];
    a_lanes = sbi_lanes(bus.hsize, bus.haddr[sbi_pkg::LANE_W-1:0]);
    completing = pend && hready_out;
    merged = mem[pend_idx];
    for (int b = 0; b < 4; b++) begin
      if (pend_lanes[b]) begin
        merged[8*b +: 8] = bus.hwdata[8*b +: 8];
      end
    end
  end

  // Next-state logic for the data phase, the storage and the user outputs.
  // With WAIT_STATES at zero, a read that follows a write to the same word is forwarded from the merged
  // value, because the storage only updates at the edge where both meet.
  always_comb begin
    next_st = st;
    next_wait_cnt = wait_cnt;
    next_hready_out = 1'b1;
    next_hresp = sbi_pkg::RESP_OKAY;
    next_hrdata = hrdata;
    next_pend = pend;
    next_pend_write = pend_write;
    next_pend_idx = pend_idx;
    next_pend_lanes = pend_lanes;
    next_mem = mem;
    next_wr_strobe = 1'b0;
    next_wr_index = wr_index;
    next_wr_word = wr_word;
    next_xfer_count = xfer_count;
    // A write lands at the edge that ends its data phase.
    if (completing) begin
      next_pend = 1'b0;
      if (pend_write) begin
        next_mem[pend_idx] = merged;
        next_wr_strobe = 1'b1;
        next_wr_index = pend_idx;
        next_wr_word = merged;
      end
    end
    case (st)
      S_IDLE: begin
        if (accept) begin
          next_xfer_count = xfer_count + ONE_W'(1);
          if (!size_ok) begin
            // Too wide for this data path: first error cycle with ready low.
            next_st = S_ERR;
            next_hready_out = 1'b0;
            next_hresp = sbi_pkg::RESP_ERROR;
          end else begin
            next_pend = 1'b1;
            next_pend_write = bus.hwrite;
            next_pend_idx = a_idx;
            next_pend_lanes = a_lanes;
            if (sbi_pkg::WAIT_STATES == 2'h0) begin
              // Zero wait: read data is ready in the very next cycle.
              if (!bus.hwrite) begin
                next_hrdata = (completing && pend_write && pend_idx == a_idx) ?
                  merged : mem[a_idx];
              end
            end else begin
              // Stretch the data phase by the wait-state count.
              next_st = S_WAIT;
              next_wait_cnt = sbi_pkg::WAIT_STATES - 2'h1;
              next_hready_out = 1'b0;
            end
          end
        end
      end
      S_WAIT: begin
        if (wait_cnt == 2'h0) begin
          // Last wait cycle; raise ready and present read data.
          next_st = S_IDLE;
          next_hready_out = 1'b1;
          if (!pend_write) begin
            next_hrdata = mem[pend_idx];
          end
        end else begin
          next_wait_cnt = wait_cnt - 2'h1;
          next_hready_out = 1'b0;
        end
      end
      S_ERR: begin
        // Second error cycle: ready high with the error still shown.
        next_st = S_IDLE;
        next_hready_out = 1'b1;
        next_hresp = sbi_pkg::RESP_ERROR;
      end
      default: begin
        next_st = S_IDLE;
      end
    endcase
  end

  // Control registers; only the reset is active low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= S_IDLE;
      wait_cnt <= 2'h0;
      hready_out <= 1'b1;
      hresp <= sbi_pkg::RESP_OKAY;
      hrdata <= 32'h0000_0000;
      pend <= 1'b0;
      pend_write <= 1'b0;
      pend_idx <= 4'h0;
      pend_lanes <= 4'h0;
      wr_strobe <= 1'b0;
      wr_index <= 4'h0;
      wr_word <= 32'h0000_0000;
      xfer_count <= 32'h0000_0000;
    end else begin
      st <= next_st;
      wait_cnt <= next_wait_cnt;
      hready_out <= next_hready_out;
      hresp <= next_hresp;
      hrdata <= next_hrdata;
      pend <= next_pend;
      pend_write <= next_pend_write;
      pend_idx <= next_pend_idx;
      pend_lanes <= next_pend_lanes;
      wr_strobe <= next_wr_strobe;
      wr_index <= next_wr_index;
      wr_word <= next_wr_word;
      xfer_count <= next_xfer_count;
    end
  end

  // Storage words are cleared at reset so reads are defined from the start.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < sbi_pkg::MEM_WORDS; i++) begin
        mem[i] <= 32'h0000_0000;
      end
    end else begin
      mem <= next_mem;
    end
  end

  // The arbitration lines are not carried by this single-master wiring, so
  // nothing here depends on their naming. Protection and burst inputs are
  // accepted but do not change how this memory answers.

endmodule : sbi_slave

// File: bench/sbi_properties.sv
// Concurrent checks on the bus wires between the master and slave ends.
`timescale 1ns/10ps
module sbi_properties (
  input wire logic clk, // Bus clock.
  input wire logic rst_n, // Active low reset.
  input wire logic [31:0] haddr, // Address bus.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic [2:0] hsize, // Transfer size.
  input wire logic [2:0] hburst, // Burst type.
  input wire logic hsel, // Slave select.
  input wire logic hready, // Bus ready.
  input wire logic hready_out, // Slave ready.
  input wire logic [1:0] hresp // Slave response.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // High when the slave takes an active transfer at this edge.
  logic taken; // Selected, ready and active.
  assign taken = hsel && hready && htrans[sbi_pkg::TRANS_ACTIVE_BIT];

  // A good transfer is stretched by exactly one wait cycle and then ends fine.
  good_wait_a: assert property (taken && hsize <= sbi_pkg::SIZE_WORD
    |=> !hready_out ##1 (hready_out && hresp == sbi_pkg::RESP_OKAY))
    else $error("good transfer did not end after one wait cycle");
  // A transfer wider than the bus gets the two-cycle error answer.
  wide_error_a: assert property (taken && hsize > sbi_pkg::SIZE_WORD
    |=> (!hready_out && hresp == sbi_pkg::RESP_ERROR)
    ##1 (hready_out && hresp == sbi_pkg::RESP_ERROR))
    else $error("wide transfer did not get the error answer");
  // Unselected or idle cycles leave the slave ready and quiet.
  unselected_quiet_a: assert property ((!hsel || !htrans[1]) && hready
    |=> hready_out && hresp == sbi_pkg::RESP_OKAY)
    else $error("slave answered a transfer not meant for it");
  // The slave never holds ready low for two cycles running.
  stretch_bound_a: assert property (!hready_out |=> hready_out)
    else $error("ready held low too long");
  // Only the two answers this slave supports ever appear.
  resp_code_a: assert property (hresp == sbi_pkg::RESP_OKAY || hresp == sbi_pkg::RESP_ERROR)
    else $error("unexpected response code");
  // The select follows the address with no register in between.
  select_decode_a: assert property (hsel == ((haddr & sbi_pkg::SLAVE_MASK) == sbi_pkg::SLAVE_BASE))
    else $error("select does not match address decode");
  // Single transfers only: a taken address phase is followed by idle.
  single_beat_a: assert property (htrans == sbi_pkg::TRANS_NONSEQ && hready
    |=> htrans == sbi_pkg::TRANS_IDLE)
    else $error("master did not go idle after its address phase");
  // The master never marks a burst.
  burst_single_a: assert property (hburst == sbi_pkg::BURST_SINGLE)
    else $error("burst code is not single");
  // While reset is low both ends sit idle and ready.
  // The first reset edge is skipped, since the flops may only take reset there.
  reset_idle_a: assert property (disable iff (1'b0) !rst_n && $past(!rst_n)
    |-> htrans == sbi_pkg::TRANS_IDLE && hready_out && hresp == sbi_pkg::RESP_OKAY)
    else $error("bus not idle during reset");

  // Main scenarios that the bench is meant to reach.
  cover property (taken && hsize <= sbi_pkg::SIZE_WORD);
  cover property (taken && hsize > sbi_pkg::SIZE_WORD);
  cover property (!hsel && htrans == sbi_pkg::TRANS_NONSEQ);
  cover property (!hready_out);
endmodule : sbi_properties

// File: bench/tb_ahb_bus_signal_interface.sv
// Self-checking bench joining the master and slave ends across one bus interface.
`timescale 1ns/10ps
module tb_ahb_bus_signal_interface;
  logic clk; // Bus clock.
  logic rst_n; // Active low reset.
  logic cmd_valid, cmd_write, cmd_ready, rsp_valid, wr_strobe; // User and store flags.
  logic [31:0] cmd_addr, cmd_wdata, rsp_data, wr_word, xfer_count; // Wide user values.
  logic [2:0] cmd_size; // Size code offered.
  logic [3:0] cmd_prot, wr_index; // Protection offered, landed word index.
  logic [1:0] rsp_code; // Response of the last transfer.
  logic [31:0] mem [16]; // Expected slave memory contents.
  logic [31:0] exp_count; // Expected count of accepted transfers.
  int err_count; // Mismatches seen.
  int n_compared; // Comparisons made.

  sbi_if i_sbi_if ();
  sbi_master i_sbi_master (.clk(clk), .rst_n(rst_n), .bus(i_sbi_if.master),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_size(cmd_size),
    .cmd_prot(cmd_prot), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_code(rsp_code));
  sbi_slave i_sbi_slave (.clk(clk), .rst_n(rst_n), .bus(i_sbi_if.slave),
    .wr_strobe(wr_strobe), .wr_index(wr_index), .wr_word(wr_word), .xfer_count(xfer_count));
  sbi_properties i_sbi_properties (.clk(clk), .rst_n(rst_n), .haddr(i_sbi_if.haddr),
    .htrans(i_sbi_if.htrans), .hsize(i_sbi_if.hsize), .hburst(i_sbi_if.hburst),
    .hsel(i_sbi_if.hsel), .hready(i_sbi_if.hready), .hready_out(i_sbi_if.hready_out),
    .hresp(i_sbi_if.hresp));

  // Prints the verdict and ends the run; also the target of the watchdog.
  task automatic finish_test();
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // Compares with case equality so an unknown never counts as a match.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One command from take to response, watching both bus phases on the way.
  // Narrow write data repeats its lane value, so either lane convention is fine.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [2:0] s,
    input logic [3:0] p, input logic [31:0] d);
    int n;
    logic sel;
    logic ok;
    logic [31:0] m;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    // A master that never comes back to idle is a failure, not a silent pass.
    if (n >= 20) begin
      err_count++;
      finish_test();
    end
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_size = s;
    cmd_prot = p;
    cmd_wdata = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    check(i_sbi_if.haddr, a);
    check(32'({i_sbi_if.htrans, i_sbi_if.hwrite, i_sbi_if.hsize, i_sbi_if.hprot}),
      32'({sbi_pkg::TRANS_NONSEQ, w, s, p}));
    @(negedge clk);
    if (w) begin
      check(i_sbi_if.hwdata, d);
    end
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    // A response that never arrives ends the run as a failure.
    if (n >= 20) begin
      err_count++;
      finish_test();
    end
    sel = ((a & sbi_pkg::SLAVE_MASK) == sbi_pkg::SLAVE_BASE);
    ok = sel && s <= sbi_pkg::SIZE_WORD;
    if (sel) begin
      exp_count++;
    end
    check(32'(rsp_code), 32'((ok || !sel) ? sbi_pkg::RESP_OKAY : sbi_pkg::RESP_ERROR));
    m = mem[a[5:2]];
    if (s == sbi_pkg::SIZE_BYTE) begin
      m[8*a[1:0] +: 8] = d[7:0];
    end else if (s == sbi_pkg::SIZE_HALF) begin
      m[16*a[1] +: 16] = d[15:0];
    end else begin
      m = d;
    end
    check(32'(wr_strobe), 32'(w && ok));
    if (w && ok) begin
      mem[a[5:2]] = m;
      check(32'(wr_index), 32'(a[5:2]));
      check(wr_word, m);
    end
    if (!w && ok) begin
      check(rsp_data, mem[a[5:2]]);
    end
  endtask : xfer

  // Free-running bus clock, 8 ns period.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Watchdog well beyond the fewer than two hundred cycles the tests need.
  initial begin
    #(8 * 3000);
    err_count++;
    finish_test();
  end

  // Main sequence of bus transfers with expected results.
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 32'h0;
    cmd_size = 3'h0;
    cmd_prot = 4'h0;
    cmd_wdata = 32'h0;
    err_count = 0;
    n_compared = 0;
    exp_count = 32'h0;
    for (int i = 0; i < 16; i++) begin
      mem[i] = 32'h0;
    end
    repeat (4) @(negedge clk);
    // The flags and the counter are checked apart so no field is cut off.
    check(32'({cmd_ready, i_sbi_if.hready, rsp_code, i_sbi_if.htrans}),
      32'({1'b1, 1'b1, sbi_pkg::RESP_OKAY, sbi_pkg::TRANS_IDLE}));
    check(xfer_count, 32'h0000_0000);
    rst_n = 1'b1;
    // Fill every word back to back, giving each protection code once.
    for (int p = 0; p < 16; p++) begin
      xfer(1'b1, 32'(4 * p), sbi_pkg::SIZE_WORD, 4'(p), 32'(p) * 32'h0101_0101);
    end
    // Narrow writes into lanes other than the lowest.
    xfer(1'b1, 32'h0000_0005, sbi_pkg::SIZE_BYTE, 4'h2, 32'h5a5a_5a5a);
    xfer(1'b1, 32'h0000_000e, sbi_pkg::SIZE_HALF, 4'h3, 32'hc3d4_c3d4);
    // Every size code wider than the bus is refused and stores nothing.
    for (int s = 3; s < 8; s++) begin
      xfer(1'b1, 32'h0000_0008, 3'(s), 4'h1, 32'hffff_ffff);
    end
    // Writes and reads outside the decoded window are ignored.
    xfer(1'b1, 32'h0000_0040, sbi_pkg::SIZE_WORD, 4'h1, 32'h7777_7777);
    xfer(1'b0, 32'h0000_0080, sbi_pkg::SIZE_WORD, 4'h1, 32'h0);
    // Read everything back to see the merged and untouched words.
    for (int p = 0; p < 16; p++) begin
      xfer(1'b0, 32'(4 * p), sbi_pkg::SIZE_WORD, 4'h1, 32'h0);
    end
    check(xfer_count, exp_count);
    repeat (2) @(negedge clk);
    finish_test();
  end
endmodule : tb_ahb_bus_signal_interface
